// *** hdl/mmutr_regs.sv ***
// Purpose: page-table descriptor, address-space pointer, segment file and
//          fault-address capture, with segment-based virtual address forming
// Assumes: special-register moves arrive as strobes with a selector code
// Notes: reads and translations answer two cycles after the request
`timescale 1ns/10ps
`include "mmutr_cfg.svh"

// Summary of operation
// - origin is descriptor bits 0-15, 64K aligned
// - at least ten hash bits, 64-byte groups
// - mask bits 23-31, contiguous ones, origin matched
// - no bridge: base pointer register all 64 bits reserved
// - bridge: origin 0-51, reserved, valid bit 63
// - unimplemented valid bit acts as set
// - valid and wide mode clear: segment compat
// - no machine check while valid clear
// - sixteen 32-bit segment registers, direct or indexed
// - keys, no-execute, segment id; reserved bits zero
// - block translation hit discards segment result
// - virtual address is id, page index, offset
// - fault address 64 or 32 bits wide
// - faulting access loads its effective address
// - narrow mode clears upper half of a captured fault address
// - size code counts mask ones, at most 28
module mmutr_regs #(
    parameter bit WIDE_IMPL = 1'b1,
    parameter bit BRIDGE_IMPL = 1'b1,
    parameter bit VALID_IMPL = 1'b1
) (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic SPR_WR_I,
    input wire logic SPR_RD_I,
    input wire logic [2:0] SPR_SEL_I,
    input wire logic [3:0] SPR_SEG_IDX_I,
    input wire logic [63:0] SPR_WDATA_I,
    output logic [63:0] SPR_RDATA_O,
    output logic SPR_RVALID_O,
    input wire logic WIDE_MODE_I,
    input wire logic XLATE_REQ_I,
    input wire logic [31:0] XLATE_EA_I,
    input wire logic BLOCK_HIT_I,
    output logic XLATE_VALID_O,
    output logic XLATE_SEG_USED_O,
    output logic [51:0] XLATE_VA_O,
    output logic XLATE_SUPV_KEY_O,
    output logic XLATE_USER_KEY_O,
    output logic XLATE_NO_EXEC_O,
    input wire logic FAULT_I,
    input wire logic [63:0] FAULT_EA_I,
    input wire logic STAB_NONEXIST_I,
    output logic MACHINE_CHECK_O,
    output logic [31:0] PT_BASE_O,
    output logic [8:0] PT_INDEX_MASK_O,
    output logic [4:0] PT_SIZE_CODE_O,
    output logic [4:0] PT_HASH_BITS_O,
    output logic [4:0] PT_TABLE_LOG2_O,
    output logic PT_CFG_OK_O,
    output logic [51:0] STAB_ORIGIN_O,
    output logic STAB_VALID_O,
    output logic SEG_COMPAT_O
);
    function automatic logic [4:0] ones_count(input logic [8:0] m);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < 9; i++) begin
            n = n + {4'h0, m[i]};
        end
        return n;
    endfunction

    function automatic logic mask_contig(input logic [8:0] m);
        logic [8:0] p;
        p = m + 9'h001;
        return (m & p) == 9'h000;
    endfunction

    mmutr_pkg::mmutr_word_t ptd_q;
    mmutr_pkg::mmutr_dword_t asp_q;
    mmutr_pkg::mmutr_dword_t flt_q;
    mmutr_pkg::mmutr_dword_t flt_d;
    mmutr_pkg::mmutr_word_t seg_rd_data;
    mmutr_pkg::mmutr_word_t seg_xl_data;
    mmutr_pkg::mmutr_sel_t rd_sel_q;
    logic rd_pend_q;
    logic xl_pend_q;
    logic xl_blk_q;
    logic [27:0] xl_ea_q;

    wire logic wr_ptd = SPR_WR_I && (SPR_SEL_I == `MMUTR_SEL_PTD);
    wire logic wr_asp = SPR_WR_I && (SPR_SEL_I == `MMUTR_SEL_ASP);
    wire logic wr_seg = SPR_WR_I && (SPR_SEL_I == `MMUTR_SEL_SEG);
    wire logic wr_flt = SPR_WR_I && (SPR_SEL_I == `MMUTR_SEL_FLT);

    // reserved descriptor bits 16-22 never store
    wire mmutr_pkg::mmutr_word_t ptd_wr_val = SPR_WDATA_I[31:0] & `MMUTR_PTD_WMASK;

    // without the bridge every pointer bit is reserved; without the valid bit it is too
    wire mmutr_pkg::mmutr_dword_t asp_wmask =
        BRIDGE_IMPL ? {52'hF_FFFF_FFFF_FFFF, 11'h000, VALID_IMPL} : 64'h0000_0000_0000_0000;
    wire mmutr_pkg::mmutr_dword_t asp_wr_val = SPR_WDATA_I & asp_wmask;

    wire mmutr_pkg::mmutr_word_t seg_wr_val = SPR_WDATA_I[31:0] & `MMUTR_SEG_WMASK;

    // narrow implementations keep only the low word; narrow mode does so for hardware captures only
    wire logic flt_narrow = !WIDE_IMPL || !WIDE_MODE_I;
    wire mmutr_pkg::mmutr_dword_t flt_cap =
        flt_narrow ? {32'h0000_0000, FAULT_EA_I[31:0]} : FAULT_EA_I;
    wire mmutr_pkg::mmutr_dword_t flt_sw =
        WIDE_IMPL ? SPR_WDATA_I : {32'h0000_0000, SPR_WDATA_I[31:0]};

    wire logic [8:0] pt_mask = ptd_q[`MMUTR_PTD_MSK_HI:`MMUTR_PTD_MSK_LO];
    wire logic [15:0] pt_org = ptd_q[`MMUTR_PTD_ORG_HI:`MMUTR_PTD_ORG_LO];
    wire logic [4:0] pt_code = ones_count(pt_mask);
    wire logic pt_ok = mask_contig(pt_mask) && ((pt_org[8:0] & pt_mask) == 9'h000) &&
        (pt_code <= `MMUTR_MAX_SIZE_CODE);

    wire logic stab_valid_bit = asp_q[`MMUTR_ASP_VALID];
    wire logic stab_eff_valid = VALID_IMPL ? stab_valid_bit : 1'b1;
    wire logic seg_compat = VALID_IMPL && !stab_valid_bit && !WIDE_MODE_I;

    mmutr_seg_mem #(
        .DEPTH(16),
        .WIDTH(32)
    ) u_seg (
        .clk_i(CLK_I),
        .reset_i(RESET_I),
        .wr_i(wr_seg),
        .wr_idx_i(SPR_SEG_IDX_I),
        .wr_data_i(seg_wr_val),
        .ra_idx_i(SPR_SEG_IDX_I),
        .ra_data_o(seg_rd_data),
        .rb_idx_i(XLATE_EA_I[31:28]),
        .rb_data_o(seg_xl_data)
    );

    // hardware capture wins over a software move in the same cycle
    always_comb begin
        flt_d = flt_q;
        if (FAULT_I) begin
            flt_d = flt_cap;
        end else if (wr_flt) begin
            flt_d = flt_sw;
        end
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            ptd_q <= `MMUTR_PTD_RESET;
            asp_q <= `MMUTR_ASP_RESET;
            flt_q <= `MMUTR_FLT_RESET;
        end else begin
            if (wr_ptd) begin
                ptd_q <= ptd_wr_val;
            end
            if (wr_asp) begin
                asp_q <= asp_wr_val;
            end
            flt_q <= flt_d;
        end
    end

    wire mmutr_pkg::mmutr_dword_t rd_mux =
        (rd_sel_q == `MMUTR_SEL_PTD) ? {32'h0000_0000, ptd_q} :
        (rd_sel_q == `MMUTR_SEL_ASP) ? asp_q :
        (rd_sel_q == `MMUTR_SEL_SEG) ? {32'h0000_0000, seg_rd_data} :
        (rd_sel_q == `MMUTR_SEL_FLT) ? flt_q : 64'h0000_0000_0000_0000;

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            rd_sel_q <= 3'h0;
            rd_pend_q <= 1'b0;
            SPR_RDATA_O <= 64'h0000_0000_0000_0000;
            SPR_RVALID_O <= 1'b0;
        end else begin
            rd_sel_q <= SPR_SEL_I;
            rd_pend_q <= SPR_RD_I;
            SPR_RVALID_O <= rd_pend_q;
            SPR_RDATA_O <= rd_pend_q ? rd_mux : 64'h0000_0000_0000_0000;
        end
    end

    // segment path result is dropped whenever block translation claimed the access
    wire logic xl_use_seg = xl_pend_q && !xl_blk_q;
    wire mmutr_pkg::mmutr_va_t xl_va =
        {seg_xl_data[`MMUTR_SEG_VID_HI:0], xl_ea_q[27:12], xl_ea_q[11:0]};

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            xl_pend_q <= 1'b0;
            xl_blk_q <= 1'b0;
            xl_ea_q <= 28'h000_0000;
            XLATE_VALID_O <= 1'b0;
            XLATE_SEG_USED_O <= 1'b0;
            XLATE_VA_O <= 52'h0_0000_0000_0000;
            XLATE_SUPV_KEY_O <= 1'b0;
            XLATE_USER_KEY_O <= 1'b0;
            XLATE_NO_EXEC_O <= 1'b0;
        end else begin
            xl_pend_q <= XLATE_REQ_I;
            xl_blk_q <= BLOCK_HIT_I;
            xl_ea_q <= XLATE_EA_I[27:0];
            XLATE_VALID_O <= xl_pend_q;
            XLATE_SEG_USED_O <= xl_use_seg;
            XLATE_VA_O <= xl_use_seg ? xl_va : 52'h0_0000_0000_0000;
            XLATE_SUPV_KEY_O <= xl_use_seg && seg_xl_data[`MMUTR_SEG_SKEY];
            XLATE_USER_KEY_O <= xl_use_seg && seg_xl_data[`MMUTR_SEG_UKEY];
            XLATE_NO_EXEC_O <= xl_use_seg && seg_xl_data[`MMUTR_SEG_NOEX];
        end
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            MACHINE_CHECK_O <= 1'b0;
            PT_BASE_O <= 32'h0000_0000;
            PT_INDEX_MASK_O <= 9'h000;
            PT_SIZE_CODE_O <= 5'h00;
            PT_HASH_BITS_O <= `MMUTR_MIN_HASH_BITS;
            PT_TABLE_LOG2_O <= `MMUTR_MIN_TABLE_LOG2;
            PT_CFG_OK_O <= 1'b1;
            STAB_ORIGIN_O <= 52'h0_0000_0000_0000;
            STAB_VALID_O <= 1'b1;
            SEG_COMPAT_O <= 1'b0;
        end else begin
            MACHINE_CHECK_O <= STAB_NONEXIST_I && stab_eff_valid;
            PT_BASE_O <= {pt_org, 16'h0000};
            PT_INDEX_MASK_O <= pt_mask;
            PT_SIZE_CODE_O <= pt_code;
            PT_HASH_BITS_O <= `MMUTR_MIN_HASH_BITS + pt_code;
            PT_TABLE_LOG2_O <= `MMUTR_MIN_TABLE_LOG2 + pt_code;
            PT_CFG_OK_O <= pt_ok;
            STAB_ORIGIN_O <= asp_q[`MMUTR_ASP_ORG_HI:`MMUTR_ASP_ORG_LO];
            STAB_VALID_O <= stab_eff_valid;
            SEG_COMPAT_O <= seg_compat;
        end
    end

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RESET_I);

    a_ptd_reserved_zero: assert property (ptd_q[15:9] == 7'h00)
        else $error("descriptor reserved bits stored");

    a_pt_base_align: assert property (PT_BASE_O[15:0] == 16'h0000)
        else $error("page table base not 64K aligned");

    a_pt_hash_floor: assert property (PT_HASH_BITS_O == PT_SIZE_CODE_O + 5'h0A)
        else $error("hash bit count not ten plus mask ones");

    a_asp_reserved_zero: assert property (asp_q[11:1] == 11'h000)
        else $error("pointer reserved bits stored");

    a_asp_nobridge: assert property (!BRIDGE_IMPL |-> asp_q == 64'h0000_0000_0000_0000)
        else $error("pointer holds data without bridge");

    a_valid_assumed: assert property (!VALID_IMPL || asp_q[0] |=> STAB_VALID_O)
        else $error("missing valid bit not treated as set");

    a_compat_mode: assert property (
        VALID_IMPL && !asp_q[0] && !WIDE_MODE_I |=> SEG_COMPAT_O)
        else $error("segment compat mode not entered");

    a_no_mchk_invalid: assert property (
        VALID_IMPL && !asp_q[0] && !wr_asp |=> !MACHINE_CHECK_O)
        else $error("machine check raised while table invalid");

    a_seg_reserved_read: assert property (
        SPR_RD_I && SPR_SEL_I == `MMUTR_SEL_SEG |-> ##2
        SPR_RVALID_O && SPR_RDATA_O[31] == 1'b0 && SPR_RDATA_O[27:24] == 4'h0)
        else $error("segment reserved bits read nonzero");

    a_block_discards: assert property (
        XLATE_REQ_I && BLOCK_HIT_I |-> ##2 XLATE_VALID_O && !XLATE_SEG_USED_O &&
        XLATE_VA_O == 52'h0_0000_0000_0000)
        else $error("segment result used on block hit");

    a_va_offset: assert property (
        XLATE_REQ_I && !BLOCK_HIT_I |-> ##2 XLATE_SEG_USED_O &&
        XLATE_VA_O[27:0] == $past(XLATE_EA_I[27:0], 2))
        else $error("virtual address page index or offset wrong");

    a_fault_capture: assert property (FAULT_I |=> flt_q[31:0] == $past(FAULT_EA_I[31:0]))
        else $error("fault address not captured");

    a_fault_narrow: assert property (
        FAULT_I && !WIDE_MODE_I |=> flt_q[63:32] == 32'h0000_0000)
        else $error("narrow fault left upper half");

    a_fault_width: assert property (!WIDE_IMPL |-> flt_q[63:32] == 32'h0000_0000)
        else $error("narrow implementation stores upper half");

    c_block_hit: cover property (XLATE_REQ_I && BLOCK_HIT_I ##2 XLATE_VALID_O);
    c_seg_xlate: cover property (XLATE_REQ_I && !BLOCK_HIT_I ##2 XLATE_SEG_USED_O);
    c_fault_over_write: cover property (FAULT_I && wr_flt);
    c_compat: cover property (SEG_COMPAT_O);
endmodule

// *** inc/mmutr_cfg.svh ***
// Purpose: constants of the translation-base register bank
// Assumes: big-endian bit n of a w-bit register is vector bit w-1-n
// Notes: selector codes pick the register on the special-register port
`ifndef MMUTR_CFG_SVH
`define MMUTR_CFG_SVH
`define MMUTR_SEL_PTD 3'h0
`define MMUTR_SEL_ASP 3'h1
`define MMUTR_SEL_SEG 3'h2
`define MMUTR_SEL_FLT 3'h3
`define MMUTR_PTD_ORG_HI 31
`define MMUTR_PTD_ORG_LO 16
`define MMUTR_PTD_MSK_HI 8
`define MMUTR_PTD_MSK_LO 0
`define MMUTR_PTD_WMASK 32'hFFFF_01FF
`define MMUTR_PTD_RESET 32'h0000_0000
`define MMUTR_ASP_ORG_HI 63
`define MMUTR_ASP_ORG_LO 12
`define MMUTR_ASP_VALID 0
`define MMUTR_ASP_RESET 64'h0000_0000_0000_0000
`define MMUTR_SEG_SKEY 30
`define MMUTR_SEG_UKEY 29
`define MMUTR_SEG_NOEX 28
`define MMUTR_SEG_VID_HI 23
`define MMUTR_SEG_WMASK 32'h70FF_FFFF
`define MMUTR_FLT_RESET 64'h0000_0000_0000_0000
`define MMUTR_MIN_HASH_BITS 5'h0A
`define MMUTR_MIN_TABLE_LOG2 5'h10
`define MMUTR_MAX_SIZE_CODE 5'h1C
`define MMUTR_XLATE_LAT 2
`endif

// *** inc/mmutr_pkg.sv ***
// Purpose: shared types of the translation-base register bank
// Assumes: nothing beyond the config header
// Notes: widths follow the register layouts
package mmutr_pkg;
    typedef logic [31:0] mmutr_word_t;
    typedef logic [63:0] mmutr_dword_t;
    typedef logic [3:0] mmutr_segidx_t;
    typedef logic [51:0] mmutr_va_t;
    typedef logic [2:0] mmutr_sel_t;
endpackage

// *** hdl/mmutr_seg_mem.sv ***
// Purpose: sixteen-entry segment descriptor file
// Assumes: one write port, two read ports, read data registered
// Notes: a read in the write cycle returns the old contents
`timescale 1ns/10ps
module mmutr_seg_mem #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 32
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic wr_i,
    input wire logic [$clog2(DEPTH)-1:0] wr_idx_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    input wire logic [$clog2(DEPTH)-1:0] ra_idx_i,
    output logic [WIDTH-1:0] ra_data_o,
    input wire logic [$clog2(DEPTH)-1:0] rb_idx_i,
    output logic [WIDTH-1:0] rb_data_o
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (wr_i) begin
            mem_q[wr_idx_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ra_data_o <= '0;
            rb_data_o <= '0;
        end else begin
            ra_data_o <= mem_q[ra_idx_i];
            rb_data_o <= mem_q[rb_idx_i];
        end
    end
endmodule

// *** verif/mmutr_regs_bench.sv ***
// Purpose: self-checking bench for the translation-base register bank
// Assumes: default parameters (wide implementation with bridge and valid bit)
// Notes: fixed-seed random stimulus with corner cases; inputs move 1 ns after the edge
`timescale 1ns/10ps
`include "mmutr_cfg.svh"
module mmutr_regs_bench;
    logic clk, rst, spr_wr, spr_rd, rvalid, wide_mode, xlate_req, blk_hit, fault, nonexist;
    logic xvalid, seg_used, skey, ukey, noex, mcheck, stab_valid, seg_compat, cfg_ok;
    logic [2:0] spr_sel;
    logic [3:0] seg_idx;
    logic [63:0] wdata, rdata, fault_ea, v, d;
    logic [31:0] xlate_ea, pt_base, ea;
    logic [51:0] va, stab_origin;
    logic [8:0] pmask;
    logic [4:0] scode, hbits, tlog2, kk;
    logic [15:0] org;
    logic [31:0] segs [16];
    int errors, comparisons;

    mmutr_regs i_dut (.CLK_I(clk), .RESET_I(rst), .SPR_WR_I(spr_wr), .SPR_RD_I(spr_rd),
        .SPR_SEL_I(spr_sel), .SPR_SEG_IDX_I(seg_idx), .SPR_WDATA_I(wdata),
        .SPR_RDATA_O(rdata), .SPR_RVALID_O(rvalid), .WIDE_MODE_I(wide_mode),
        .XLATE_REQ_I(xlate_req), .XLATE_EA_I(xlate_ea), .BLOCK_HIT_I(blk_hit),
        .XLATE_VALID_O(xvalid), .XLATE_SEG_USED_O(seg_used), .XLATE_VA_O(va),
        .XLATE_SUPV_KEY_O(skey), .XLATE_USER_KEY_O(ukey), .XLATE_NO_EXEC_O(noex),
        .FAULT_I(fault), .FAULT_EA_I(fault_ea), .STAB_NONEXIST_I(nonexist),
        .MACHINE_CHECK_O(mcheck), .PT_BASE_O(pt_base), .PT_INDEX_MASK_O(pmask),
        .PT_SIZE_CODE_O(scode), .PT_HASH_BITS_O(hbits), .PT_TABLE_LOG2_O(tlog2),
        .PT_CFG_OK_O(cfg_ok), .STAB_ORIGIN_O(stab_origin), .STAB_VALID_O(stab_valid),
        .SEG_COMPAT_O(seg_compat));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // strobe is lowered one cycle before the next task may raise it
    task automatic wr_reg(input logic [2:0] s, input logic [3:0] i, input logic [63:0] dd);
        spr_wr = 1'b1;
        spr_sel = s;
        seg_idx = i;
        wdata = dd;
        step(1);
        spr_wr = 1'b0;
        step(1);
    endtask

    task automatic rd_reg(input logic [2:0] s, input logic [3:0] i, output logic [63:0] dd);
        int n;
        spr_rd = 1'b1;
        spr_sel = s;
        seg_idx = i;
        step(1);
        spr_rd = 1'b0;
        n = 1;
        while (rvalid !== 1'b1 && n < 5) begin
            step(1);
            n++;
        end
        chk(64'(n), 64'd2);
        dd = rdata;
    endtask

    // expected segment-path result: keys, no-execute, then the virtual address
    function automatic logic [55:0] exp_x(input logic [31:0] s, input logic [31:0] e,
                                         input logic b);
        return b ? 56'h0 : {1'b1, s[30], s[29], s[28], s[23:0], e[27:0]};
    endfunction

    task automatic xl(input logic [31:0] e, input logic b);
        int n;
        xlate_req = 1'b1;
        xlate_ea = e;
        blk_hit = b;
        step(1);
        xlate_req = 1'b0;
        n = 1;
        while (xvalid !== 1'b1 && n < 5) begin
            step(1);
            n++;
        end
        chk(64'(n), 64'd2);
        chk({seg_used, skey, ukey, noex, va}, exp_x(segs[e[31:28]], e, b));
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #(20000 * 8);
        errors++;
        close_out();
    end

    initial begin
        {spr_wr, spr_rd, wide_mode, xlate_req, blk_hit, fault, nonexist} = 7'h0;
        spr_sel = 3'h0;
        seg_idx = 4'h0;
        wdata = 64'h0;
        fault_ea = 64'h0;
        xlate_ea = 32'h0;
        errors = 0;
        comparisons = 0;
        rst = 1'b1;
        v = 64'($urandom(32'h6d37627a));
        step(3);
        chk({hbits, tlog2, cfg_ok}, {5'h0A, 5'h10, 1'b1});
        rst = 1'b0;
        step(1);
        // descriptor: every mask length from none to nine ones
        for (int k = 0; k < 10; k++) begin
            kk = 5'(k);
            org = 16'($urandom) & ~16'((1 << k) - 1);
            d = {32'($urandom), org, 7'($urandom), 9'((1 << k) - 1)};
            wr_reg(`MMUTR_SEL_PTD, 4'h0, d);
            rd_reg(`MMUTR_SEL_PTD, 4'h0, v);
            chk(v, {32'h0, d[31:16], 7'h0, d[8:0]});
            chk({pt_base, pmask}, {org, 16'h0, d[8:0]});
            chk({scode, hbits, tlog2, cfg_ok}, {kk, kk + 5'h0A, kk + 5'h10, 1'b1});
        end
        wr_reg(`MMUTR_SEL_PTD, 4'h0, 64'h0000_0000_0000_0105);
        chk(cfg_ok, 1'b0);
        wr_reg(`MMUTR_SEL_PTD, 4'h0, 64'h0000_0000_0001_0001);
        chk(cfg_ok, 1'b0);
        $display("test descriptor done");
        // address-space pointer over both valid and both mode settings
        for (int c = 0; c < 4; c++) begin
            wide_mode = c[1];
            d = {32'($urandom), 31'($urandom), c[0]};
            wr_reg(`MMUTR_SEL_ASP, 4'h0, d);
            rd_reg(`MMUTR_SEL_ASP, 4'h0, v);
            chk(v, d & 64'hFFFF_FFFF_FFFF_F001);
            chk({stab_origin, stab_valid, seg_compat}, {d[63:12], c[0], ~c[0] & ~c[1]});
            nonexist = 1'b1;
            step(1);
            nonexist = 1'b0;
            chk(mcheck, c[0]);
        end
        $display("test pointer done");
        // segment file written by number, read back, then used for translation
        for (int i = 0; i < 16; i++) begin
            d = {32'($urandom), 32'($urandom)};
            segs[i] = d[31:0] & 32'h70FF_FFFF;
            wr_reg(`MMUTR_SEL_SEG, 4'(i), d);
        end
        for (int i = 0; i < 16; i++) begin
            rd_reg(`MMUTR_SEL_SEG, 4'(i), v);
            chk(v, {32'h0, segs[i]});
        end
        for (int i = 0; i < 40; i++) begin
            ea = $urandom;
            xl(ea, ($urandom % 4) == 0);
        end
        $display("test segments done");
        // fault capture in narrow and wide mode, then a software write
        for (int m = 0; m < 2; m++) begin
            wide_mode = m[0];
            fault_ea = {32'($urandom), 32'($urandom)};
            fault = 1'b1;
            step(1);
            fault = 1'b0;
            rd_reg(`MMUTR_SEL_FLT, 4'h0, v);
            chk(v, m[0] ? fault_ea : {32'h0, fault_ea[31:0]});
        end
        // capture and software write in one cycle: the capture wins
        fault = 1'b1;
        spr_wr = 1'b1;
        spr_sel = `MMUTR_SEL_FLT;
        wdata = 64'h0000_0000_0000_0000;
        step(1);
        {fault, spr_wr} = 2'b00;
        rd_reg(`MMUTR_SEL_FLT, 4'h0, v);
        chk(v, fault_ea);
        d = {32'($urandom), 32'($urandom)};
        wr_reg(`MMUTR_SEL_FLT, 4'h0, d);
        rd_reg(`MMUTR_SEL_FLT, 4'h0, v);
        chk(v, d);
        wr_reg(3'h5, 4'h0, d);
        rd_reg(3'h5, 4'h0, v);
        chk(v, 64'h0);
        $display("test fault and unmapped done");
        // reset in mid-run restores the reset outputs and clears the fault register
        rst = 1'b1;
        step(2);
        chk({pt_base, stab_valid, hbits, xvalid}, {32'h0, 1'b1, 5'h0A, 1'b0});
        rst = 1'b0;
        step(1);
        rd_reg(`MMUTR_SEL_FLT, 4'h0, v);
        chk(v, 64'h0);
        $display("test reset done");
        close_out();
    end
endmodule
